// ### shared/vsw_params.svh
// Constants of the video switch control register block.
// Included by the register block and its bench by bare name; definitions only.
`ifndef VSW_PARAMS_SVH
`define VSW_PARAMS_SVH
// Sub-address decode values
`define VSW_SUB_SINK1   8'h01
`define VSW_SUB_SINK2   8'h02
`define VSW_SUB_STATUS  8'h03
// Power-up values
`define VSW_PTR_RST     8'h03
`define VSW_SINK1_RST   8'h08
`define VSW_SINK2_RST   8'h09
`define VSW_STATUS_RST  8'h10
// Fixed upper five bits of the device address
`define VSW_DEV_FIXED   5'h0b
// Sink register fields
`define VSW_RSV_MSB     7
`define VSW_RSV_LSB     5
`define VSW_BIT_DEEMPH  4
`define VSW_BIT_DDC     3
`define VSW_BIT_OE_N    2
`define VSW_BIT_SEL_HI  1
`define VSW_BIT_SEL_LO  0
// Status register fields
`define VSW_BIT_PRIO    5
`define VSW_BIT_GATE    4
// Bits per byte on the serial line
`define VSW_BYTE_BITS   4'h8
`endif

// ### shared/vsw_pkg.sv
// Types of the video switch control register block.
// Constants live in vsw_params.svh.
package vsw_pkg;
    typedef logic [7:0] vsw_byte_t;
    // Serial slave protocol states
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK,
        ST_DATA, ST_DATA_ACK, ST_TX, ST_TX_ACK, ST_SKIP
    } vsw_state_t;
endpackage : vsw_pkg

// ### shared/vsw_line_if.sv
// Carrier of sampled serial-line events from the pin sampler to the slave.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface vsw_line_if;
    logic scl_rise;   // Clock line rose
    logic scl_fall;   // Clock line fell
    logic sda_lvl;    // Synchronised data level
    logic start_seen; // Start or repeated start
    logic stop_seen;  // Stop
    modport src (output scl_rise, scl_fall, sda_lvl, start_seen, stop_seen);
    modport dst (input scl_rise, scl_fall, sda_lvl, start_seen, stop_seen);
endinterface : vsw_line_if
`default_nettype wire

// ### design/vsw_line_sampler.sv
// Samples the two serial bus pins and finds clock edges, start and stop.
// Assumes pins are asynchronous to clock and far slower than it.
`timescale 1ns/10ps
`default_nettype none
module vsw_line_sampler (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic scl_in,
    input  wire logic sda_in,
    vsw_line_if.src   ln
);
    logic [1:0] meta_ff; // First stage, read only by sync_ff
    logic [1:0] sync_ff; // {scl, sda} second stage
    logic [1:0] prev_ff; // Previous synced value

    // Two-flop synchroniser then history stage
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= 2'h3;
            sync_ff <= 2'h3;
            prev_ff <= 2'h3;
        end else begin
            meta_ff <= {scl_in, sda_in};
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // Edge and condition decode
    assign ln.scl_rise   = sync_ff[1] & ~prev_ff[1];
    assign ln.scl_fall   = ~sync_ff[1] & prev_ff[1];
    assign ln.sda_lvl    = sync_ff[0];
    assign ln.start_seen = sync_ff[1] & prev_ff[1] & prev_ff[0] & ~sync_ff[0];
    assign ln.stop_seen  = sync_ff[1] & prev_ff[1] & ~prev_ff[0] & sync_ff[0];
endmodule : vsw_line_sampler
`default_nettype wire

// ### design/vsw_ctrl_regs.sv
// Serial-bus slave and control registers of a four-in, two-out video switch.
// Assumes the bus master keeps single-byte transfers; pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none
`include "vsw_params.svh"
module vsw_ctrl_regs (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    input  wire logic       addr_select_hi,
    input  wire logic       addr_select_lo,
    input  wire logic [3:0] source_power_present,
    output logic [1:0]      sink_source_sel_hi,
    output logic [1:0]      sink_source_sel_lo,
    output logic [1:0]      sink_deemph_on,
    output logic [1:0]      sink_ddc_buffer_on,
    output logic [1:0]      sink_video_oe_n,
    output logic [3:0]      source_ddc_buffer_on,
    output logic            main_display_priority,
    output logic            power_gates_output
);
    import vsw_pkg::*;

    vsw_line_if ln ();
    vsw_state_t state_ff;
    logic [3:0] cnt_ff;      // Bits seen in the current byte
    vsw_byte_t  shreg_ff;    // Receive shift register
    vsw_byte_t  tx_ff;       // Transmit shift register
    vsw_byte_t  ptr_ff;      // Sub-address pointer
    logic       rw_ff;       // Direction bit of the address byte
    logic       drive_ff;    // Pull data line low
    vsw_byte_t  cfg_ff [2];  // Sink configuration registers
    logic [1:0] stat_ff;     // {priority, power gating}
    logic [5:0] pin_meta_ff; // First stage, read only by pin_ff
    logic [5:0] pin_ff;      // {addr hi, addr lo, power 4..1}
    logic       byte_end;
    logic       ack_slot;    // Ninth clock of a byte
    logic       addr_match;
    logic       commit;
    logic [3:0] pres;
    vsw_byte_t  rd_val;

    vsw_line_sampler u_sampler (
        .clock  (clock),
        .rst_n  (rst_n),
        .scl_in (scl_in),
        .sda_in (sda_in),
        .ln     (ln)
    );

    // Synchronise select and power pins
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_ff <= 6'h00;
            pin_ff      <= 6'h00;
        end else begin
            pin_meta_ff <= {addr_select_hi, addr_select_lo, source_power_present};
            pin_ff      <= pin_meta_ff;
        end
    end

    assign pres = pin_ff[3:0];
    // Falling clock after the eighth bit closes a byte
    assign byte_end = ln.scl_fall && (cnt_ff == `VSW_BYTE_BITS);
    // Acknowledge clocks carry no payload bit
    assign ack_slot = state_ff inside {ST_ADDR_ACK, ST_SUB_ACK, ST_DATA_ACK, ST_TX_ACK};
    // Fixed bits plus live select pins, compared every time
    assign addr_match = (shreg_ff[7:3] == `VSW_DEV_FIXED)
                      && (shreg_ff[2:1] == pin_ff[5:4]);
    // Write takes effect at the end of the data acknowledge
    assign commit = (state_ff == ST_DATA_ACK) && ln.scl_fall;

    // Readback of the selected register
    always_comb begin
        unique case (ptr_ff)
            `VSW_SUB_SINK1:  rd_val = cfg_ff[0];
            `VSW_SUB_SINK2:  rd_val = cfg_ff[1];
            `VSW_SUB_STATUS: rd_val = {2'b00, stat_ff, pres};
            default:         rd_val = 8'h00;
        endcase
    end

    // Protocol state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
        end else if (ln.start_seen) begin
            state_ff <= ST_ADDR;
        end else if (ln.stop_seen) begin
            state_ff <= ST_IDLE;
        end else begin
            unique case (state_ff)
                ST_IDLE, ST_SKIP: begin
                    state_ff <= state_ff;
                end
                ST_ADDR: begin
                    if (byte_end) begin
                        state_ff <= addr_match ? ST_ADDR_ACK : ST_SKIP;
                    end
                end
                ST_ADDR_ACK: begin
                    if (ln.scl_fall) begin
                        state_ff <= rw_ff ? ST_TX : ST_SUB;
                    end
                end
                ST_SUB: begin
                    if (byte_end) begin
                        state_ff <= ST_SUB_ACK;
                    end
                end
                ST_SUB_ACK: begin
                    if (ln.scl_fall) begin
                        state_ff <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (byte_end) begin
                        state_ff <= ST_DATA_ACK;
                    end
                end
                ST_DATA_ACK: begin
                    if (ln.scl_fall) begin
                        state_ff <= ST_SKIP;
                    end
                end
                ST_TX: begin
                    if (byte_end) begin
                        state_ff <= ST_TX_ACK;
                    end
                end
                ST_TX_ACK: begin
                    if (ln.scl_fall) begin
                        state_ff <= ST_SKIP;
                    end
                end
            endcase
        end
    end

    // Bit counter and receive shift, sampled on rising clock; the ninth
    // clock is skipped so the next byte counts from zero and the data
    // byte stays intact until it is committed
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff   <= 4'h0;
            shreg_ff <= 8'h00;
        end else if (ln.start_seen || byte_end) begin
            cnt_ff <= 4'h0;
        end else if (ln.scl_rise && !ack_slot) begin
            cnt_ff   <= cnt_ff + 4'h1;
            shreg_ff <= {shreg_ff[6:0], ln.sda_lvl};
        end
    end

    // Direction bit and sub-address pointer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rw_ff  <= 1'b0;
            ptr_ff <= `VSW_PTR_RST;
        end else if (byte_end && state_ff == ST_ADDR) begin
            rw_ff <= shreg_ff[0];
        end else if (byte_end && state_ff == ST_SUB) begin
            ptr_ff <= shreg_ff;
        end
    end

    // Data line drive: acks and transmitted bits
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            drive_ff <= 1'b0;
            tx_ff    <= 8'h00;
        end else if (ln.start_seen || ln.stop_seen) begin
            drive_ff <= 1'b0;
        end else if (ln.scl_fall) begin
            unique case (state_ff)
                ST_ADDR: begin
                    drive_ff <= byte_end && addr_match;
                end
                ST_SUB, ST_DATA: begin
                    drive_ff <= byte_end;
                end
                ST_ADDR_ACK: begin
                    drive_ff <= rw_ff && !rd_val[7];
                    tx_ff    <= {rd_val[6:0], 1'b0};
                end
                ST_TX: begin
                    drive_ff <= !byte_end && !tx_ff[7];
                    tx_ff    <= {tx_ff[6:0], 1'b0};
                end
                default: begin
                    drive_ff <= 1'b0;
                end
            endcase
        end
    end

    // Open-drain data pin: only ever pulls low
    assign sda_out  = 1'b0;
    assign sda_oe_n = ~drive_ff;

    // Status control bits
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stat_ff <= 2'(`VSW_STATUS_RST >> `VSW_BIT_GATE);
        end else if (commit && ptr_ff == `VSW_SUB_STATUS) begin
            stat_ff <= shreg_ff[`VSW_BIT_PRIO:`VSW_BIT_GATE];
        end
    end

    // Source side: buffer follows power presence
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            source_ddc_buffer_on  <= 4'h0;
            main_display_priority <= 1'b0;
            power_gates_output    <= 1'b1;
        end else begin
            source_ddc_buffer_on  <= pres;
            main_display_priority <= stat_ff[1];
            power_gates_output    <= stat_ff[0];
        end
    end

    // Per-sink configuration and effective controls
    for (genvar s = 0; s < 2; s++) begin : g_sink
        localparam vsw_byte_t RST = (s == 0) ? `VSW_SINK1_RST : `VSW_SINK2_RST;
        localparam vsw_byte_t SUB = (s == 0) ? `VSW_SUB_SINK1 : `VSW_SUB_SINK2;
        logic [1:0] sel;
        logic       gated;
        assign sel   = cfg_ff[s][`VSW_BIT_SEL_HI:`VSW_BIT_SEL_LO];
        assign gated = stat_ff[0] && !pres[sel];

        // Register write, reserved bits kept zero
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                cfg_ff[s] <= RST;
            end else if (commit && ptr_ff == SUB) begin
                cfg_ff[s] <= {3'b000, shreg_ff[4:0]};
            end
        end

        // Registered sink controls
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                sink_source_sel_hi[s] <= 1'b0;
                sink_source_sel_lo[s] <= 1'b0;
                sink_deemph_on[s]     <= 1'b0;
                sink_ddc_buffer_on[s] <= 1'b0;
                sink_video_oe_n[s]    <= 1'b1;
            end else begin
                sink_source_sel_hi[s] <= sel[1];
                sink_source_sel_lo[s] <= sel[0];
                sink_deemph_on[s]     <= cfg_ff[s][`VSW_BIT_DEEMPH];
                sink_ddc_buffer_on[s] <= cfg_ff[s][`VSW_BIT_DDC];
                sink_video_oe_n[s]    <= cfg_ff[s][`VSW_BIT_OE_N] || gated;
            end
        end
    end

    // Checks on the protocol and register behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    chk_reset_values: assert property ($rose(rst_n) |->
        ptr_ff == `VSW_PTR_RST && cfg_ff[0] == `VSW_SINK1_RST
        && cfg_ff[1] == `VSW_SINK2_RST && stat_ff == 2'b01)
        else $error("power-up register values wrong");

    chk_addr_ack: assert property (
        state_ff == ST_ADDR && byte_end && addr_match
        |=> (!sda_oe_n until_with ln.scl_fall))
        else $error("matching address not acknowledged");

    chk_addr_nack: assert property (
        state_ff == ST_ADDR && byte_end && !addr_match |=> sda_oe_n
        && state_ff == ST_SKIP)
        else $error("foreign address acknowledged");

    chk_data_ack: assert property (
        state_ff inside {ST_SUB, ST_DATA} && byte_end |=> !sda_oe_n)
        else $error("sub-address or data byte not acknowledged");

    chk_single_byte: assert property (
        state_ff == ST_DATA_ACK && ln.scl_fall && !ln.stop_seen
        && !ln.start_seen |=> state_ff == ST_SKIP ##1 sda_oe_n)
        else $error("second data byte accepted");

    chk_reserved_zero: assert property (
        cfg_ff[0][7:5] == 3'b000 && cfg_ff[1][7:5] == 3'b000
        && (ptr_ff != `VSW_SUB_STATUS || rd_val[7:6] == 2'b00))
        else $error("reserved bits not zero");

    chk_write_commit: assert property (
        $changed(cfg_ff[0]) || $changed(cfg_ff[1]) || $changed(stat_ff)
        |-> $past(commit))
        else $error("register changed outside data acknowledge");

    chk_bad_sub: assert property (
        commit && !(ptr_ff inside {`VSW_SUB_SINK1, `VSW_SUB_SINK2,
        `VSW_SUB_STATUS}) |=> $stable(cfg_ff[0]) && $stable(cfg_ff[1])
        && $stable(stat_ff))
        else $error("undefined sub-address changed a register");

    chk_tx_msb: assert property (
        state_ff == ST_ADDR_ACK && rw_ff && ln.scl_fall
        && !ln.stop_seen && !ln.start_seen |=> sda_oe_n == $past(rd_val[7]))
        else $error("read byte not sent msb first");

    chk_video_gate: assert property (
        stat_ff[0] && !pres[cfg_ff[0][1:0]] ##1 $stable(pres)
        && $stable(cfg_ff[0]) && $stable(stat_ff) |-> sink_video_oe_n[0])
        else $error("video driven from unpowered source");

    cov_write_sink: cover property (commit && ptr_ff == `VSW_SUB_SINK1);
    cov_read_byte: cover property (state_ff == ST_TX_ACK && ln.scl_fall);
    cov_foreign: cover property (state_ff == ST_ADDR && byte_end && !addr_match);
    cov_gated: cover property (sink_video_oe_n[1] && !cfg_ff[1][2]);
endmodule : vsw_ctrl_regs
`default_nettype wire

// ### dv/vsw_bus_master.sv
// Behavioural two-wire bus master that drives the block's serial pins.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module vsw_bus_master (
    output logic      scl,
    output logic      sda,
    input  wire logic sda_w
);
    localparam realtime QTR = 31.25; // Quarter of the 125 ns bit period
    logic [7:0] rd_data;
    event       rd_ev;

    // Both lines idle high between frames
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // Data falls while the clock is high
    task automatic start();
        sda = 1'b0;
        #QTR scl = 1'b0;
    endtask

    // One clock pulse; data set mid-low, sampled mid-high
    task automatic one_bit(input logic b, output logic r);
        #QTR sda = b;
        #QTR scl = 1'b1;
        #QTR r = sda_w;
        #QTR scl = 1'b0;
    endtask

    // Byte out, then release the line for the ninth clock
    task automatic tx(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            one_bit(b[i], r);
        end
        one_bit(1'b1, ack);
    endtask

    // One byte in, then not-acknowledge so the device stops sending
    task automatic rx();
        logic r;
        for (int i = 7; i >= 0; i--) begin
            one_bit(1'b1, r);
            rd_data[i] = r;
        end
        one_bit(1'b1, r);
        -> rd_ev;
    endtask

    // Data rises while the clock is high; each transaction closes here
    task automatic stop();
        #QTR sda = 1'b0;
        #QTR scl = 1'b1;
        #QTR sda = 1'b1;
        #QTR;
    endtask
endmodule // vsw_bus_master
`default_nettype wire

// ### dv/vsw_ctrl_regs_tb.sv
// Self-checking bench of the video switch control registers.
// Assumes vsw_params.svh on the include path and the bus master model.
`timescale 1ns/10ps
`default_nettype none
`include "vsw_params.svh"
module vsw_ctrl_regs_tb;
    import vsw_pkg::*;
    logic            clock, rst_n, addr_select_hi, addr_select_lo;
    logic [3:0]      source_power_present;
    wire logic       scl_m, sda_m, sda_out, sda_oe_n, prio, gate;
    wire logic [1:0] sel_hi, sel_lo, deemph, ddc, voe_n;
    wire logic [3:0] src_buf;
    wire logic       sda_w = sda_m & (sda_oe_n | sda_out);
    vsw_byte_t       s1_e, s2_e, st_e;
    logic [31:0]     d;
    integer          seed;
    int              failures, checks;
    logic [15:0]     rdq[$], outq[$];
    event            snap_ev;

    vsw_ctrl_regs DUT (.clock(clock), .rst_n(rst_n), .scl_in(scl_m), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_select_hi(addr_select_hi),
        .addr_select_lo(addr_select_lo), .source_power_present(source_power_present),
        .sink_source_sel_hi(sel_hi), .sink_source_sel_lo(sel_lo), .sink_deemph_on(deemph),
        .sink_ddc_buffer_on(ddc), .sink_video_oe_n(voe_n), .source_ddc_buffer_on(src_buf),
        .main_display_priority(prio), .power_gates_output(gate));
    vsw_bus_master host (.scl(scl_m), .sda(sda_m), .sda_w(sda_w));

    // 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // Expected output bundle from the modelled registers
    function automatic logic [15:0] exp_out();
        logic [7:0] c;
        logic [1:0] vo;
        for (int s = 0; s < 2; s++) begin
            c = s ? s2_e : s1_e;
            vo[s] = c[2] | (st_e[4] & ~source_power_present[c[1:0]]);
        end
        return {vo, s2_e[1], s1_e[1], s2_e[0], s1_e[0], s2_e[4], s1_e[4], s2_e[3], s1_e[3],
                source_power_present, st_e[5], st_e[4]};
    endfunction

    function automatic logic [7:0] rd_exp(input logic [7:0] sub);
        case (sub)
            8'h01: return s1_e;
            8'h02: return s2_e;
            8'h03: return {2'b00, st_e[5:4], source_power_present};
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] dev(input logic rw);
        return {`VSW_DEV_FIXED, addr_select_hi, addr_select_lo, rw};
    endfunction

    // Write transaction; nd data bytes, hit says whether the device should answer
    task automatic wr(input logic [7:0] a, input logic [7:0] sub, input logic [7:0] dat,
                      input int nd, input logic hit);
        logic ack;
        host.start();
        host.tx(a, ack);
        cmp(ack, !hit);
        host.tx(sub, ack);
        cmp(ack, !hit);
        if (nd > 0) begin
            host.tx(dat, ack);
            cmp(ack, !hit);
        end
        if (nd > 1) begin
            host.tx(~dat, ack);
            cmp(ack, 1'b1);
        end
        host.stop();
        if (hit && nd > 0) begin
            case (sub)
                8'h01: s1_e = dat & 8'h1f;
                8'h02: s2_e = dat & 8'h1f;
                8'h03: st_e = dat & 8'h30;
                default: ;
            endcase
        end
    endtask

    // Optional pointer write, then a one-byte read
    task automatic rd(input logic [7:0] sub, input logic setp);
        logic ack;
        if (setp) begin
            wr(dev(1'b0), sub, 8'h00, 0, 1'b1);
        end
        rdq.push_back({8'h00, rd_exp(sub)});
        host.start();
        host.tx(dev(1'b1), ack);
        cmp(ack, 1'b0);
        host.rx();
        host.stop();
    endtask

    // Let synchronisers settle, then note the expected outputs
    task automatic snap();
        repeat (6) @(negedge clock);
        outq.push_back(exp_out());
        -> snap_ev;
    endtask

    task automatic pins(input logic [3:0] p, input logic [1:0] a);
        @(negedge clock);
        source_power_present = p;
        {addr_select_hi, addr_select_lo} = a;
        repeat (6) @(negedge clock);
    endtask

    task automatic end_of_test();
        $display("Checks %0d, failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Result watchers take the oldest note
    always @(snap_ev) cmp({voe_n, sel_hi, sel_lo, deemph, ddc, src_buf, prio, gate},
                          outq.pop_front());
    always @(host.rd_ev) cmp({8'h00, host.rd_data}, rdq.pop_front());

    // Watchdog: about twice the expected run of some 17,000 clocks
    initial begin
        #400_000;
        failures++;
        $display("ERROR at %0t ns: watchdog expired", $time);
        end_of_test();
    end

    initial begin
        seed = 10214;
        rst_n = 1'b0;
        source_power_present = 4'h0;
        addr_select_hi = 1'b0;
        addr_select_lo = 1'b0;
        s1_e = 8'h08;
        s2_e = 8'h09;
        st_e = 8'h10;
        repeat (10) @(negedge clock);
        rst_n = 1'b1;
        pins(4'h5, 2'b10);
        snap();
        rd(8'h03, 1'b0);
        rd(8'h01, 1'b1);
        rd(8'h02, 1'b1);
        $display("Test power-up finished");
        // Every source code on both sinks, random other fields
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            wr(dev(1'b0), 8'h01, {d[7:2], i[1:0]}, 1, 1'b1);
            wr(dev(1'b0), 8'h02, {d[15:10], 2'(3 - i)}, 1, 1'b1);
            snap();
            rd(8'h01, 1'b1);
            rd(8'h02, 1'b1);
        end
        $display("Test sink fields finished");
        // Gating on and off with random power presence
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            pins(d[3:0], d[5:4]);
            wr(dev(1'b0), 8'h03, {d[15:13], i[0], d[11:8]}, 1, 1'b1);
            wr(dev(1'b0), 8'h01, {d[23:19], 1'b0, d[17:16]}, 1, 1'b1);
            wr(dev(1'b0), 8'h02, {d[31:27], 1'b0, d[25:24]}, 1, 1'b1);
            snap();
            rd(8'h03, 1'b1);
        end
        $display("Test power gating finished");
        // Undefined sub-addresses 00 and 04 change nothing; 00 reads zero
        wr(dev(1'b0), 8'h00, 8'hff, 1, 1'b1);
        wr(dev(1'b0), 8'h04, 8'hff, 1, 1'b1);
        rd(8'h00, 1'b1);
        snap();
        $display("Test undefined sub-address finished");
        // Wrong select bits refused; new pin levels take effect unlatched
        wr(dev(1'b0) ^ 8'h06, 8'h01, 8'h1f, 1, 1'b0);
        snap();
        pins(source_power_present, 2'b01);
        wr(dev(1'b0), 8'h01, 8'h14, 1, 1'b1);
        snap();
        $display("Test device address finished");
        // A second data byte is refused and ignored
        wr(dev(1'b0), 8'h02, 8'h13, 2, 1'b1);
        snap();
        rd(8'h02, 1'b1);
        $display("Test burst refusal finished");
        end_of_test();
    end
endmodule // vsw_ctrl_regs_tb
`default_nettype wire
